// ---- core/lnbsa_pkg.sv ----
/*
  constants for the converter supervision and alarm routing block.
  assumes one 200 MHz clock and configuration held by the control processor.
*/
package lnbsa_pkg;
  // -----------------------------------------------------------------
  // widths and limits
  // -----------------------------------------------------------------
  localparam int          CUR_W       = 9;
  localparam logic [8:0]  CUR_MAX_MA  = 9'h1F4;
  // LO frequency in 4 Hz steps: 49999.999996 MHz over 4 Hz fits 34 bits
  localparam int          LO_W        = 34;
  localparam logic [33:0] LO_MAX      = 34'h2E90EDCFF;
  localparam int          N_SRC       = 7;
  // -----------------------------------------------------------------
  // source indices and route codes
  // -----------------------------------------------------------------
  localparam int          SRC_LOCK    = 0;
  localparam int          SRC_LEVEL   = 1;
  localparam int          SRC_EBNO    = 2;
  localparam int          SRC_TEST    = 3;
  localparam int          SRC_HW      = 4;
  localparam int          SRC_BACK    = 5;
  localparam int          SRC_PWR     = 6;
  localparam logic [1:0]  ROUTE_A_BIT = 2'h1;
  localparam logic [1:0]  ROUTE_B_BIT = 2'h2;
  localparam int          MUTE_BIT    = 2;
  localparam logic [1:0]  PWR_OFF     = 2'h0;
  localparam logic [1:0]  PWR_13V     = 2'h1;
  localparam logic [1:0]  PWR_18V     = 2'h2;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [8:0]  RST_HIGH    = 9'h1F4;
  localparam logic [8:0]  RST_LOW     = 9'h000;
endpackage

// ---- core/lnbsa_route.sv ----
/*
  one alarm source with its destination code.
  assumes fault and code are synchronous to mclk.
*/
`timescale 1ns/1ps
module lnbsa_route (
  // source
  input  wire logic       fault,
  input  wire logic [2:0] code,
  input  wire logic       present,
  // contribution
  output logic            to_a,
  output logic            to_b,
  output logic            to_mute
);
  import lnbsa_pkg::*;
  always_comb begin
    to_a    = present & fault & code[0];
    to_b    = present & fault & code[1];
    to_mute = present & fault & code[MUTE_BIT];
  end
endmodule

// ---- core/lnbsa_top.sv ----
/*
  converter supervision and alarm routing for the receive side.
  assumes the control processor drives settings as plain levels, and an ADC
  path supplies the converter current already scaled to mA.
*/
`timescale 1ns/1ps
module lnbsa_top #(
  parameter bit HAS_MUX  = 1'b1,
  parameter bit HAS_PWR  = 1'b1
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  // settings
  input  wire logic [lnbsa_pkg::CUR_W-1:0] converter_current_high_limit,
  input  wire logic [lnbsa_pkg::CUR_W-1:0] converter_current_low_limit,
  input  wire logic                        converter_ref_enable_set,
  input  wire logic [lnbsa_pkg::LO_W-1:0]  lo_freq_set,
  input  wire logic                        if_loopback_set,
  input  wire logic [1:0]                  power_select_set,
  input  wire logic [2:0]                  carrier_lock_alarm_route,
  input  wire logic [1:0]                  low_level_route,
  input  wire logic [1:0]                  low_ebno_route,
  input  wire logic [1:0]                  test_active_route,
  input  wire logic [1:0]                  hardware_route,
  input  wire logic [1:0]                  backward_route,
  input  wire logic [1:0]                  converter_power_alarm_route,
  // fault sources
  input  wire logic                        lock_fault,
  input  wire logic                        level_fault,
  input  wire logic                        ebno_fault,
  input  wire logic                        test_fault,
  input  wire logic                        hw_fault,
  input  wire logic                        backward_fault,
  input  wire logic [lnbsa_pkg::CUR_W-1:0] current_meas,
  // readback and controls
  output logic      [lnbsa_pkg::CUR_W-1:0] current_ma,
  output logic      [lnbsa_pkg::LO_W-1:0]  lo_freq,
  output logic                             if_is_rf,
  output logic                             converter_ref_enable,
  output logic                             if_loopback,
  output logic                             power_13v_en,
  output logic                             power_18v_en,
  output logic                             power_alarm,
  output logic                             alarm_a,
  output logic                             alarm_b,
  output logic                             carrier_mute
);
  import lnbsa_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CUR_W-1:0] cur;
    logic [CUR_W-1:0] hi;
    logic [CUR_W-1:0] lo;
    logic [LO_W-1:0]  lof;
    logic             rf;
    logic             ref_en;
    logic             loop;
    logic             p13;
    logic             p18;
    logic             palarm;
    logic             a;
    logic             b;
    logic             mute;
  } lnbsa_state_t;

  lnbsa_state_t st;
  lnbsa_state_t next_st;

  logic [N_SRC-1:0]   src_fault;
  logic [N_SRC-1:0]   src_present;
  logic [3*N_SRC-1:0] src_code;
  logic [N_SRC-1:0]   to_a;
  logic [N_SRC-1:0]   to_b;
  logic [N_SRC-1:0]   to_mute;
  logic               cur_above;
  logic               cur_below;
  logic               supply_on;
  logic               pwr_fault;
  logic [CUR_W-1:0]   hi_clamped;
  logic [CUR_W-1:0]   lo_clamped;
  logic [LO_W-1:0]    lof_clamped;
  logic               sel_13v;
  logic               sel_18v;

  // ---------------------------------------------------------------
  // converter current supervision
  // ---------------------------------------------------------------
  // limit check runs on the registered limits, so an alarm lags a limit write by two cycles, one more than a measurement change
  assign cur_above = (current_meas > st.hi);
  assign cur_below = (current_meas < st.lo);
  // an unpowered converter draws nothing, which would hold the low limit alarm forever
  assign supply_on = st.p13 | st.p18;
  assign pwr_fault = supply_on & (cur_above | cur_below);

  // ---------------------------------------------------------------
  // fault sources
  // ---------------------------------------------------------------
  assign src_fault[SRC_LOCK]  = lock_fault;
  assign src_fault[SRC_LEVEL] = level_fault;
  assign src_fault[SRC_EBNO]  = ebno_fault;
  assign src_fault[SRC_TEST]  = test_fault;
  assign src_fault[SRC_HW]    = hw_fault;
  assign src_fault[SRC_BACK]  = backward_fault;
  assign src_fault[SRC_PWR]   = pwr_fault;

  // ---------------------------------------------------------------
  // source presence by build option
  // ---------------------------------------------------------------
  assign src_present[SRC_LOCK]  = 1'b1;
  assign src_present[SRC_LEVEL] = 1'b1;
  assign src_present[SRC_EBNO]  = 1'b1;
  assign src_present[SRC_TEST]  = 1'b1;
  assign src_present[SRC_HW]    = 1'b1;
  assign src_present[SRC_BACK]  = HAS_MUX;
  assign src_present[SRC_PWR]   = HAS_PWR;

  // ---------------------------------------------------------------
  // destination codes
  // ---------------------------------------------------------------
  // only the lock source carries a mute bit; the others pad it with zero
  assign src_code[3*SRC_LOCK+:3]  = carrier_lock_alarm_route;
  assign src_code[3*SRC_LEVEL+:3] = {1'b0, low_level_route};
  assign src_code[3*SRC_EBNO+:3]  = {1'b0, low_ebno_route};
  assign src_code[3*SRC_TEST+:3]  = {1'b0, test_active_route};
  assign src_code[3*SRC_HW+:3]    = {1'b0, hardware_route};
  assign src_code[3*SRC_BACK+:3]  = {1'b0, backward_route};
  assign src_code[3*SRC_PWR+:3]   = {1'b0, converter_power_alarm_route};

  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_src
      lnbsa_route u_route (
        .fault   (src_fault[gi]),
        .code    (src_code[3*gi +: 3]),
        .present (src_present[gi]),
        .to_a    (to_a[gi]),
        .to_b    (to_b[gi]),
        .to_mute (to_mute[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // setting clamps
  // ---------------------------------------------------------------
  // out-of-range settings are clamped rather than refused
  always_comb begin
    hi_clamped  = converter_current_high_limit;
    lo_clamped  = converter_current_low_limit;
    lof_clamped = lo_freq_set;
    if (converter_current_high_limit > CUR_MAX_MA) begin
      hi_clamped = CUR_MAX_MA;
    end
    if (converter_current_low_limit > CUR_MAX_MA) begin
      lo_clamped = CUR_MAX_MA;
    end
    if (lo_freq_set > LO_MAX) begin
      lof_clamped = LO_MAX;
    end
  end

  // ---------------------------------------------------------------
  // converter power select
  // ---------------------------------------------------------------
  always_comb begin
    sel_13v = 1'b0;
    sel_18v = 1'b0;
    case (power_select_set)
      PWR_OFF: begin
        sel_13v = 1'b0;
        sel_18v = 1'b0;
      end
      PWR_13V: begin
        sel_13v = HAS_PWR;
      end
      PWR_18V: begin
        sel_18v = HAS_PWR;
      end
      // the spare code keeps the supply off rather than guessing a voltage
      default: begin
        sel_13v = 1'b0;
        sel_18v = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.cur    = current_meas;
    next_st.hi     = hi_clamped;
    next_st.lo     = lo_clamped;
    next_st.lof    = lof_clamped;
    next_st.rf     = (lof_clamped != '0);
    next_st.ref_en = converter_ref_enable_set;
    next_st.loop   = if_loopback_set;
    next_st.p13    = sel_13v;
    next_st.p18    = sel_18v;
    next_st.palarm = pwr_fault;
    next_st.a      = |to_a;
    next_st.b      = |to_b;
    next_st.mute   = to_mute[SRC_LOCK];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st    <= '0;
      st.hi <= RST_HIGH;
      st.lo <= RST_LOW;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign current_ma           = st.cur;
  assign lo_freq              = st.lof;
  assign if_is_rf             = st.rf;
  assign converter_ref_enable = st.ref_en;
  assign if_loopback          = st.loop;
  assign power_13v_en         = st.p13;
  assign power_18v_en         = st.p18;
  assign power_alarm          = st.palarm;
  assign alarm_a              = st.a;
  assign alarm_b              = st.b;
  assign carrier_mute         = st.mute;
endmodule

// ---- dv/lnbsa_chk.sv ----
/* port assertions for the converter supervision block.
   assumes the single clock mclk and asynchronous active-low arst_n. */
`timescale 1ns/1ps
module lnbsa_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // watched ports
  input wire logic [8:0]  current_meas,
  input wire logic [8:0]  current_ma,
  input wire logic [33:0] lo_freq,
  input wire logic        if_is_rf,
  input wire logic        converter_ref_enable_set,
  input wire logic        converter_ref_enable,
  input wire logic        if_loopback_set,
  input wire logic        if_loopback,
  input wire logic [1:0]  power_select_set,
  input wire logic        power_18v_en,
  input wire logic        lock_fault,
  input wire logic [2:0]  carrier_lock_alarm_route,
  input wire logic        alarm_a,
  input wire logic        alarm_b,
  input wire logic        carrier_mute
);
  // ---------------------------------------------
  // one-cycle output relations, plus the same-cycle rf flag relation
  // ---------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_cur_echo: assert property ($past(arst_n) |-> current_ma == $past(current_meas))
    else $error("current readback wrong");
  a_lock_to_a: assert property ($past(arst_n) && $past(lock_fault)
    && $past(carrier_lock_alarm_route[0]) |-> alarm_a) else $error("lock not on a");
  a_lock_to_b: assert property ($past(arst_n) && $past(lock_fault)
    && $past(carrier_lock_alarm_route[1]) |-> alarm_b) else $error("lock not on b");
  a_mute_lock: assert property ($past(arst_n)
    |-> carrier_mute == $past(lock_fault && carrier_lock_alarm_route[2]))
    else $error("mute wrong");
  a_ref_copy: assert property ($past(arst_n)
    |-> converter_ref_enable == $past(converter_ref_enable_set)) else $error("ref wrong");
  a_loop_copy: assert property ($past(arst_n)
    |-> if_loopback == $past(if_loopback_set)) else $error("loopback wrong");
  a_rf_flag: assert property (if_is_rf == (lo_freq != 34'h0))
    else $error("rf flag wrong");
  a_pwr_pick: assert property ($past(arst_n)
    |-> power_18v_en == ($past(power_select_set) == 2'h2)) else $error("18 V wrong");
endmodule
bind lnbsa_top lnbsa_chk u_chk (.mclk, .arst_n, .current_meas, .current_ma, .lo_freq,
  .if_is_rf, .converter_ref_enable_set, .converter_ref_enable, .if_loopback_set,
  .if_loopback, .power_select_set, .power_18v_en, .lock_fault, .carrier_lock_alarm_route,
  .alarm_a, .alarm_b, .carrier_mute);

// ---- dv/tb_top.sv ----
/* self-checking bench for the converter supervision block.
   assumes the block's default variant with mux and power options. */
`timescale 1ns/1ps
module tb_top;
  import lnbsa_pkg::*;
  // ---------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------
  logic mclk = 0, arst_n = 0, converter_ref_enable_set = 0, if_loopback_set = 0;
  logic lock_fault = 0, level_fault = 0, ebno_fault = 0, test_fault = 0;
  logic hw_fault = 0, backward_fault = 0;
  logic [8:0] converter_current_high_limit = 9'h1F4, converter_current_low_limit = 9'h000;
  logic [8:0] current_meas = 9'h000, current_ma;
  logic [33:0] lo_freq_set = 34'h0, lo_freq;
  logic [2:0] carrier_lock_alarm_route = 3'h0;
  logic [1:0] power_select_set = 2'h0, low_level_route = 2'h0, low_ebno_route = 2'h0;
  logic [1:0] test_active_route = 2'h0, hardware_route = 2'h0, backward_route = 2'h0;
  logic [1:0] converter_power_alarm_route = 2'h0;
  logic if_is_rf, converter_ref_enable, if_loopback, power_13v_en, power_18v_en;
  logic power_alarm, alarm_a, alarm_b, carrier_mute;
  int mismatches = 0, n_tests = 0, cyc = 0;
  lnbsa_top DUT (.mclk, .arst_n, .converter_current_high_limit, .converter_current_low_limit,
    .converter_ref_enable_set, .lo_freq_set, .if_loopback_set, .power_select_set,
    .carrier_lock_alarm_route, .low_level_route, .low_ebno_route, .test_active_route,
    .hardware_route, .backward_route, .converter_power_alarm_route, .lock_fault, .level_fault,
    .ebno_fault, .test_fault, .hw_fault, .backward_fault, .current_meas, .current_ma, .lo_freq,
    .if_is_rf, .converter_ref_enable, .if_loopback, .power_13v_en, .power_18v_en,
    .power_alarm, .alarm_a, .alarm_b, .carrier_mute);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      mismatches++;
      end_sim;
    end
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic end_sim;
    $display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // three edges cover the two-cycle power path, then sample mid-cycle
  task automatic settle;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic cur(input logic [8:0] hi, lo, m, input logic e);
    @(posedge mclk);
    converter_current_high_limit <= hi;
    converter_current_low_limit <= lo;
    current_meas <= m;
    settle;
    chk(current_ma, m);
    chk({power_alarm, alarm_b, alarm_a}, {3{e}});
  endtask
  task automatic cfg(input logic r, l, input logic [33:0] lo, e);
    @(posedge mclk);
    converter_ref_enable_set <= r;
    if_loopback_set <= l;
    lo_freq_set <= lo;
    settle;
    chk({converter_ref_enable, if_loopback}, {r, l});
    chk(lo_freq, e);
    chk(if_is_rf, e != 34'h0);
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge mclk);
      lock_fault <= 1'b1;
      carrier_lock_alarm_route <= c[2:0];
      settle;
      chk({carrier_mute, alarm_b, alarm_a}, c);
    end
    @(posedge mclk);
    lock_fault <= 1'b0;
    settle;
    chk(carrier_mute, 1'b0);
    $display("test lock routing done");
    for (int s = 0; s < 6; s++)
      for (int c = 0; c < 4; c++) begin
        @(posedge mclk);
        {backward_fault, hw_fault, test_fault, ebno_fault, level_fault} <= 5'h01 << s;
        {low_level_route, low_ebno_route, test_active_route} <= {3{c[1:0]}};
        {hardware_route, backward_route, converter_power_alarm_route} <= {3{c[1:0]}};
        settle;
        chk({alarm_b, alarm_a}, s < 5 ? c : 0);
      end
    $display("test source routing done");
    @(posedge mclk);
    power_select_set <= PWR_13V;
    converter_power_alarm_route <= 2'h3;
    settle;
    chk({power_18v_en, power_13v_en}, 2'h1);
    cur(9'h12C, 9'h096, 9'h0DD, 1'b0);
    cur(9'h12C, 9'h096, 9'h12D, 1'b1);
    cur(9'h12C, 9'h096, 9'h12C, 1'b0);
    cur(9'h12C, 9'h096, 9'h095, 1'b1);
    cur(9'h12C, 9'h096, 9'h096, 1'b0);
    cur(9'h1FF, 9'h000, 9'h1F5, 1'b1);
    cur(9'h1FF, 9'h000, 9'h1F4, 1'b0);
    @(posedge mclk);
    power_select_set <= PWR_18V;
    settle;
    chk({power_18v_en, power_13v_en}, 2'h2);
    $display("test converter current done");
    cfg(1'b1, 1'b1, 34'h1, 34'h1);
    cfg(1'b0, 1'b0, 34'h3FFFFFFFF, LO_MAX);
    cfg(1'b1, 1'b0, 34'h0, 34'h0);
    $display("test settings done");
    @(posedge mclk);
    arst_n <= 1'b0;
    @(negedge mclk);
    chk({current_ma, power_18v_en, converter_ref_enable}, 11'h000);
    chk({if_is_rf, if_loopback, power_13v_en, power_alarm, alarm_b, alarm_a, carrier_mute},
        7'h00);
    @(posedge mclk);
    arst_n <= 1'b1;
    settle;
    chk({current_ma, power_18v_en, converter_ref_enable}, {9'h1F4, 2'h3});
    $display("test reset done");
    end_sim;
  end
endmodule
